// ### inc/aep_pkg.sv
// Package for the active energy accumulator with calibration pulse output.
// Assumes a single 200 MHz master clock and a simple strobed register port.
package aep_pkg;
  // Register indices on the address port
  localparam logic [7:0] ADDR_ENERGY = 8'h00;
  localparam logic [7:0] ADDR_CLR_ENERGY = 8'h01;
  localparam logic [7:0] ADDR_DIVIDER = 8'h02;
  localparam logic [7:0] ADDR_NUM = 8'h03;
  localparam logic [7:0] ADDR_DEN = 8'h04;
  localparam logic [7:0] ADDR_SELECT = 8'h05;
  localparam logic [7:0] ADDR_OFS_A = 8'h06;
  localparam logic [7:0] ADDR_OFS_B = 8'h07;
  localparam logic [7:0] ADDR_OFS_C = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h09;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0A;
  localparam logic [7:0] ADDR_GAIN = 8'h18;
  // Field positions
  localparam int GAIN_NLT_OFF_BIT = 3;
  localparam int HF_POS_BIT = 0;
  localparam int HF_NEG_BIT = 1;
  // Reset values
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [2:0] SELECT_RST = 3'h7;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  // Arithmetic sizes
  localparam int ACC_W = 54;
  localparam int VIEW_W = 24;
  localparam int OFS_W = 12;
  localparam int CF_W = 12;
  localparam int NO_LOAD_LEVEL = 687;
  // Timing
  localparam int SAMPLE_CYCLES = 4;
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int CF_PULSE_NS = 40;
  localparam int CF_PULSE_CYCLES = (CF_PULSE_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
endpackage : aep_pkg

// ### src/aep_energy.sv
// Active energy accumulator, divided energy views, half-full flags and
// calibration pulse stage. Power samples come from logic on mclk; the
// register port is driven by a master on the same clock.
`timescale 1ns/100ps

module aep_energy #(
  parameter int PWR_W = 24,
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Per-phase active power samples
  input wire logic signed [PWR_W-1:0] pwr_a,
  input wire logic signed [PWR_W-1:0] pwr_b,
  input wire logic signed [PWR_W-1:0] pwr_c,
  // Register port
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // Event and pulse outputs
  output logic irq_req,
  output logic calibration_pulse_out
);
  localparam int AC = aep_pkg::ACC_W;
  localparam int VW = aep_pkg::VIEW_W;

  initial begin
    if (PWR_W < 11 || PWR_W > 40) $error("aep_energy: PWR_W out of range");
    if (AW < 5) $error("aep_energy: AW too small for map");
  end

  // Zero a deselected phase; under the threshold, with no-load on, keep only its offset
  function automatic logic signed [AC-1:0] phase_term(
    input logic signed [PWR_W-1:0] p,
    input logic signed [aep_pkg::OFS_W-1:0] ofs,
    input logic sel,
    input logic nlt_on
  );
    logic signed [AC-1:0] pw;
    logic signed [AC-1:0] mag;
    pw = AC'(p);
    mag = (pw < 0) ? -pw : pw;
    if (!sel) begin
      phase_term = '0;
    end else if (nlt_on && mag < AC'(aep_pkg::NO_LOAD_LEVEL)) begin
      phase_term = AC'(ofs);
    end else begin
      phase_term = pw + AC'(ofs);
    end
  endfunction : phase_term

  // Zero in a 12-bit scale register is taken as one
  function automatic logic [aep_pkg::CF_W-1:0] nz(input logic [aep_pkg::CF_W-1:0] v);
    nz = (v == '0) ? aep_pkg::CF_W'(1) : v;
  endfunction : nz

  logic [7:0] divider_r;
  logic [aep_pkg::CF_W-1:0] num_r;
  logic [aep_pkg::CF_W-1:0] den_r;
  logic [7:0] gain_r;
  logic [2:0] select_r;
  logic signed [aep_pkg::OFS_W-1:0] ofs_a_r;
  logic signed [aep_pkg::OFS_W-1:0] ofs_b_r;
  logic signed [aep_pkg::OFS_W-1:0] ofs_c_r;
  logic [1:0] irq_en_r;
  logic [1:0] hf_flag_r;
  logic [1:0] tick_cnt_r;
  logic signed [AC-1:0] acc_r;
  logic [VW-1:0] energy_prev_r;
  logic hf_prev_pos_r;
  logic hf_prev_neg_r;
  logic clr_done_r;
  logic [aep_pkg::CF_W:0] frac_r;
  logic [7:0] cf_cnt_r;
  logic cf_r;
  logic irq_r;
  logic [31:0] rd_data_r;

  logic tick;
  logic clr_read;
  logic nlt_on;
  logic signed [AC-1:0] sum;
  logic signed [AC-1:0] quot;
  logic [VW-1:0] energy_now;
  logic lsb_pulse;
  logic hf_pos;
  logic hf_neg;
  logic [1:0] hf_set;
  logic [1:0] hf_clr;
  logic [aep_pkg::CF_W:0] frac_sum;
  logic cf_fire;

  assign tick = (tick_cnt_r == 2'(aep_pkg::SAMPLE_CYCLES - 1));
  assign clr_read = rd_en && addr == AW'(aep_pkg::ADDR_CLR_ENERGY);
  assign nlt_on = !gain_r[aep_pkg::GAIN_NLT_OFF_BIT];
  assign sum = phase_term(pwr_a, ofs_a_r, select_r[0], nlt_on)
             + phase_term(pwr_b, ofs_b_r, select_r[1], nlt_on)
             + phase_term(pwr_c, ofs_c_r, select_r[2], nlt_on);
  // Combinational divide: large, but keeps the views exact every cycle
  assign quot = acc_r / $signed({46'h0, (divider_r == 8'h00) ? 8'h01 : divider_r});
  assign energy_now = quot[AC-1:AC-VW];
  // Views wrap modulo 2^24 because the accumulator wraps modulo 2^54
  assign hf_pos = energy_now[VW-1:VW-2] == 2'b01;
  assign hf_neg = energy_now[VW-1:VW-2] == 2'b10;
  // Clearing is not energy; its view step shows one cycle after the read
  assign lsb_pulse = (energy_now != energy_prev_r) && !clr_done_r;
  assign frac_sum = frac_r + {1'b0, nz(num_r)};
  assign cf_fire = lsb_pulse && (frac_sum >= {1'b0, nz(den_r)});
  assign hf_set = {hf_neg && !hf_prev_neg_r, hf_pos && !hf_prev_pos_r};
  assign hf_clr = (wr_en && addr == AW'(aep_pkg::ADDR_STATUS)) ? wr_data[1:0] : 2'b00;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 2'h1;
    end
  end

  // A clearing read in a sample cycle drops that sample with the old content
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= '0;
    end else if (clr_read) begin
      acc_r <= '0;
    end else if (tick) begin
      acc_r <= acc_r + sum;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      divider_r <= '0;
      num_r <= '0;
      den_r <= '0;
      gain_r <= aep_pkg::GAIN_RST;
      select_r <= aep_pkg::SELECT_RST;
      ofs_a_r <= '0;
      ofs_b_r <= '0;
      ofs_c_r <= '0;
      irq_en_r <= aep_pkg::IRQ_EN_RST;
    end else if (wr_en) begin
      unique case (addr)
        AW'(aep_pkg::ADDR_DIVIDER): divider_r <= wr_data[7:0];
        AW'(aep_pkg::ADDR_NUM): num_r <= wr_data[11:0];
        AW'(aep_pkg::ADDR_DEN): den_r <= wr_data[11:0];
        AW'(aep_pkg::ADDR_GAIN): gain_r <= wr_data[7:0];
        AW'(aep_pkg::ADDR_SELECT): select_r <= wr_data[2:0];
        AW'(aep_pkg::ADDR_OFS_A): ofs_a_r <= wr_data[11:0];
        AW'(aep_pkg::ADDR_OFS_B): ofs_b_r <= wr_data[11:0];
        AW'(aep_pkg::ADDR_OFS_C): ofs_c_r <= wr_data[11:0];
        AW'(aep_pkg::ADDR_IRQ_EN): irq_en_r <= wr_data[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_data_r <= '0;
    end else if (rd_en) begin
      unique case (addr)
        AW'(aep_pkg::ADDR_ENERGY), AW'(aep_pkg::ADDR_CLR_ENERGY): begin
          rd_data_r <= {8'h00, energy_now};
        end
        AW'(aep_pkg::ADDR_DIVIDER): rd_data_r <= {24'h0, divider_r};
        AW'(aep_pkg::ADDR_NUM): rd_data_r <= {20'h0, num_r};
        AW'(aep_pkg::ADDR_DEN): rd_data_r <= {20'h0, den_r};
        AW'(aep_pkg::ADDR_GAIN): rd_data_r <= {24'h0, gain_r};
        AW'(aep_pkg::ADDR_SELECT): rd_data_r <= {29'h0, select_r};
        AW'(aep_pkg::ADDR_OFS_A): rd_data_r <= {20'h0, ofs_a_r};
        AW'(aep_pkg::ADDR_OFS_B): rd_data_r <= {20'h0, ofs_b_r};
        AW'(aep_pkg::ADDR_OFS_C): rd_data_r <= {20'h0, ofs_c_r};
        AW'(aep_pkg::ADDR_STATUS): rd_data_r <= {30'h0, hf_flag_r};
        AW'(aep_pkg::ADDR_IRQ_EN): rd_data_r <= {30'h0, irq_en_r};
        default: rd_data_r <= '0;
      endcase
    end else begin
      rd_data_r <= '0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hf_prev_pos_r <= 1'b0;
      hf_prev_neg_r <= 1'b0;
      energy_prev_r <= '0;
      clr_done_r <= 1'b0;
    end else begin
      hf_prev_pos_r <= hf_pos;
      hf_prev_neg_r <= hf_neg;
      energy_prev_r <= energy_now;
      clr_done_r <= clr_read;
    end
  end

  // Write one to clear; a same-cycle set wins
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hf_flag_r <= '0;
    end else begin
      hf_flag_r <= (hf_flag_r & ~hf_clr) | hf_set;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(hf_flag_r & irq_en_r);
    end
  end

  // Ratios above one fire at most once per LSB, so the rate saturates
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      frac_r <= '0;
    end else if (lsb_pulse) begin
      frac_r <= cf_fire ? frac_sum - {1'b0, nz(den_r)} : frac_sum;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cf_cnt_r <= '0;
      cf_r <= 1'b0;
    end else if (cf_fire && !cf_r) begin
      cf_cnt_r <= 8'(aep_pkg::CF_PULSE_CYCLES - 1);
      cf_r <= 1'b1;
    end else if (cf_cnt_r != 8'h00) begin
      cf_cnt_r <= cf_cnt_r - 8'h01;
    end else begin
      cf_r <= 1'b0;
    end
  end

  assign rd_data = rd_data_r;
  assign irq_req = irq_r;
  assign calibration_pulse_out = cf_r;

  // Checks
  property p_tick_period;
    @(posedge mclk) disable iff (!nrst) tick |=> !tick [*3] ##1 tick;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("sample spacing wrong");

  property p_add;
    @(posedge mclk) disable iff (!nrst)
      (tick && !clr_read) |=> acc_r == $past(acc_r) + $past(sum);
  endproperty
  a_add: assert property (p_add) else $error("accumulate mismatch");

  property p_clear;
    @(posedge mclk) disable iff (!nrst) clr_read |=> acc_r == '0;
  endproperty
  a_clear: assert property (p_clear) else $error("clearing read kept energy");

  property p_plain;
    @(posedge mclk) disable iff (!nrst)
      (rd_en && addr == AW'(aep_pkg::ADDR_ENERGY) && !tick) |=> acc_r == $past(acc_r);
  endproperty
  a_plain: assert property (p_plain) else $error("plain read changed energy");

  property p_view;
    @(posedge mclk) disable iff (!nrst)
      (rd_en && (addr == AW'(aep_pkg::ADDR_ENERGY) || addr == AW'(aep_pkg::ADDR_CLR_ENERGY)))
      |=> rd_data == {8'h00, $past(energy_now)};
  endproperty
  a_view: assert property (p_view) else $error("energy view data wrong");

  property p_div_one;
    @(posedge mclk) disable iff (!nrst)
      divider_r <= 8'h01 |-> energy_now == acc_r[AC-1:AC-VW];
  endproperty
  a_div_one: assert property (p_div_one) else $error("divide by one wrong");

  property p_nlt;
    @(posedge mclk) disable iff (!nrst)
      (nlt_on && select_r == 3'h1 && pwr_a < 687 && pwr_a > -687)
      |-> sum == AC'(ofs_a_r);
  endproperty
  a_nlt: assert property (p_nlt) else $error("creep not suppressed");

  sequence s_cf_high;
    cf_r [*8];
  endsequence
  property p_cf_width;
    @(posedge mclk) disable iff (!nrst) $rose(cf_r) |-> s_cf_high ##1 !cf_r;
  endproperty
  a_cf_width: assert property (p_cf_width) else $error("pulse width wrong");

  property p_hf_sticky;
    @(posedge mclk) disable iff (!nrst)
      (hf_flag_r[0] && !hf_clr[0]) |=> hf_flag_r[0];
  endproperty
  a_hf_sticky: assert property (p_hf_sticky) else $error("flag dropped");

  property p_hf_irq;
    @(posedge mclk) disable iff (!nrst)
      (hf_set[0] && irq_en_r[0] && hf_clr == 2'b00 && $stable(irq_en_r)) |-> ##2 irq_req;
  endproperty
  a_hf_irq: assert property (p_hf_irq) else $error("half-full request missing");

  property p_unity;
    @(posedge mclk) disable iff (!nrst)
      (nz(num_r) == nz(den_r) && lsb_pulse && frac_r == '0) |-> cf_fire;
  endproperty
  a_unity: assert property (p_unity) else $error("unity ratio skipped pulse");
endmodule : aep_energy

// ### verification/aep_cf_counter.sv
// External counter that watches the calibration pulse output.
// Assumes the pulse output is synchronous to mclk and idles low.
`timescale 1ns/100ps
module aep_cf_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Watched pulse
  input wire logic cf,
  // What was seen
  output logic [15:0] pulse_cnt,
  output logic [15:0] last_width
);
  logic [15:0] run_r;

  // Width counted in cycles; a real counter would only see edges
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      run_r <= 16'h0000;
      pulse_cnt <= 16'h0000;
      last_width <= 16'h0000;
    end else if (cf) begin
      run_r <= run_r + 16'h0001;
    end else if (run_r != 16'h0000) begin
      pulse_cnt <= pulse_cnt + 16'h0001;
      last_width <= run_r;
      run_r <= 16'h0000;
    end
  end
endmodule : aep_cf_counter

// ### verification/aep_energy_tb_top.sv
// Self-checking bench for the energy accumulator and pulse stage.
// Assumes power held at zero between bursts and zero power offsets
// outside the short offset check.
`timescale 1ns/100ps
module aep_energy_tb_top;
  logic mclk;
  logic nrst;
  logic signed [23:0] pwr_a;
  logic signed [23:0] pwr_b;
  logic signed [23:0] pwr_c;
  logic [7:0] addr;
  logic [31:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [31:0] rd_data;
  logic irq_req;
  logic cf;
  logic [15:0] pulse_cnt;
  logic [15:0] last_width;
  logic [31:0] d;
  logic [15:0] base;
  int error_cnt;
  int checks;

  aep_energy #(.PWR_W(24), .AW(8)) dut (.mclk(mclk), .nrst(nrst), .pwr_a(pwr_a),
    .pwr_b(pwr_b), .pwr_c(pwr_c), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .irq_req(irq_req), .calibration_pulse_out(cf));
  aep_cf_counter partner (.mclk(mclk), .nrst(nrst), .cf(cf), .pulse_cnt(pulse_cnt),
    .last_width(last_width));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected reg at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_reg

  task automatic cmp_cnt(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected count at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_cnt

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rd_data;
  endtask : rd

  // Any 4*m consecutive cycles hold exactly m sample cycles
  task automatic burst(input logic [2:0] ph, input logic signed [23:0] x, input int m);
    @(posedge mclk);
    pwr_a <= ph[0] ? x : 24'sh000000;
    pwr_b <= ph[1] ? x : 24'sh000000;
    pwr_c <= ph[2] ? x : 24'sh000000;
    repeat (4 * m) @(posedge mclk);
    pwr_a <= 24'sh000000;
    pwr_b <= 24'sh000000;
    pwr_c <= 24'sh000000;
    repeat (16) @(posedge mclk);
  endtask : burst

  task automatic t_regs();
    rd(aep_pkg::ADDR_GAIN, d);
    cmp_reg(d, 32'h00000000);
    rd(aep_pkg::ADDR_SELECT, d);
    cmp_reg(d, 32'h00000007);
    rd(8'h20, d);
    cmp_reg(d, 32'h00000000);
    wr(8'h20, 32'h0000005A);
    rd(8'h20, d);
    cmp_reg(d, 32'h00000000);
    wr(aep_pkg::ADDR_NUM, 32'h00000ABC);
    rd(aep_pkg::ADDR_NUM, d);
    cmp_reg(d, 32'h00000ABC);
    wr(aep_pkg::ADDR_ENERGY, 32'h00000123);
    rd(aep_pkg::ADDR_ENERGY, d);
    cmp_reg(d, 32'h00000000);
    wr(aep_pkg::ADDR_GAIN, 32'h00000008);
    rd(aep_pkg::ADDR_GAIN, d);
    cmp_reg(d, 32'h00000008);
    wr(aep_pkg::ADDR_GAIN, 32'h00000000);
    wr(aep_pkg::ADDR_IRQ_EN, 32'h00000003);
    rd(aep_pkg::ADDR_IRQ_EN, d);
    cmp_reg(d, 32'h00000003);
    rd(aep_pkg::ADDR_STATUS, d);
    cmp_reg(d, 32'h00000000);
  endtask : t_regs

  task automatic t_accum();
    wr(aep_pkg::ADDR_NUM, 32'h00000000);
    wr(aep_pkg::ADDR_DEN, 32'h00000000);
    wr(aep_pkg::ADDR_SELECT, 32'h00000001);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    base = pulse_cnt;
    burst(3'b001, 24'sh400000, 512);
    rd(aep_pkg::ADDR_ENERGY, d);
    cmp_reg(d, 32'h00000002);
    rd(aep_pkg::ADDR_ENERGY, d);
    cmp_reg(d, 32'h00000002);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00000002);
    rd(aep_pkg::ADDR_ENERGY, d);
    cmp_reg(d, 32'h00000000);
    repeat (16) @(posedge mclk);
    cmp_cnt(pulse_cnt - base, 16'h0002);
    cmp_cnt(last_width, 16'(aep_pkg::CF_PULSE_CYCLES));
  endtask : t_accum

  task automatic t_neg_div();
    burst(3'b001, 24'shC00000, 256);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00FFFFFF);
    wr(aep_pkg::ADDR_DIVIDER, 32'h00000002);
    burst(3'b001, 24'sh400000, 512);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00000001);
    wr(aep_pkg::ADDR_DIVIDER, 32'h00000000);
  endtask : t_neg_div

  task automatic t_sel();
    wr(aep_pkg::ADDR_SELECT, 32'h00000005);
    burst(3'b111, 24'sh400000, 256);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00000002);
    wr(aep_pkg::ADDR_SELECT, 32'h00000007);
  endtask : t_sel

  // Negative power makes any leak visible as an all-ones view
  task automatic t_nlt();
    burst(3'b001, -24'sd686, 4);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00000000);
    burst(3'b001, -24'sd687, 4);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00FFFFFF);
    wr(aep_pkg::ADDR_GAIN, 32'h00000008);
    burst(3'b001, -24'sd686, 4);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00FFFFFF);
    wr(aep_pkg::ADDR_GAIN, 32'h00000000);
    wr(aep_pkg::ADDR_OFS_A, 32'h00000FFF);
    repeat (8) @(posedge mclk);
    rd(aep_pkg::ADDR_ENERGY, d);
    cmp_reg(d, 32'h00FFFFFF);
    wr(aep_pkg::ADDR_OFS_A, 32'h00000000);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
  endtask : t_nlt

  // Ratio kept below one, as software is expected to do
  task automatic t_scale();
    wr(aep_pkg::ADDR_NUM, 32'h00000001);
    wr(aep_pkg::ADDR_DEN, 32'h00000002);
    wr(aep_pkg::ADDR_SELECT, 32'h00000001);
    base = pulse_cnt;
    burst(3'b001, 24'sh400000, 1024);
    rd(aep_pkg::ADDR_CLR_ENERGY, d);
    cmp_reg(d, 32'h00000004);
    cmp_cnt(pulse_cnt - base, 16'h0002);
    cmp_reg({31'h00000000, irq_req}, 32'h00000000);
  endtask : t_scale

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    error_cnt = 0;
    checks = 0;
    nrst = 1'b0;
    pwr_a = 24'sh000000;
    pwr_b = 24'sh000000;
    pwr_c = 24'sh000000;
    addr = 8'h00;
    wr_data = 32'h00000000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_accum();
    t_neg_div();
    t_sel();
    t_nlt();
    t_scale();
    wrap_up();
  end
endmodule : aep_energy_tb_top
